// ==== src/dyndly_top.sv ====
// Dynamic digital delay control for the clock output divider pairs.
// How it works
// R1: Effective delay is the count, less one half when half step is set.
// R2: One delay unit equals one distribution clock period, two ref_clk cycles.
// R3: Host programs zero offset as (ceil(16/div)+0.5)*div-11.5.
// R4: The pair named by qualifier_select is the alignment reference.
// R5: Resyncing the qualifier pair itself shifts its phase again each sync.
// R6: Host sets half step for the sync, then rewrites it afterwards.
// R7: Delays below 4.5 are not supported; they are raised to 4.5.
// R8: A delay one qualifier period longer gives same phase, longer off time.
// R9: Only pairs taking part in a sync stop; all others run untouched.
// R10: Zero-offset value depends only on the qualifier divide.
// R11: Host moves the phase one step by changing the delay by one half.
// R12: Written settings take effect only at the next sync event.
`timescale 1ns/1ps
module dyndly_top (
    input  wire logic                                        ref_clk,
    input  wire logic                                        reset_n,
    input  wire logic                                        sync_req,
    input  wire logic [dyndly_pkg::SEL_W-1:0]                qualifier_select,
    input  wire logic [dyndly_pkg::NUM_PAIRS-1:0]            sync_enable,
    input  wire dyndly_pkg::dyndly_cfg_t [dyndly_pkg::NUM_PAIRS-1:0] pair_cfg,
    output logic [dyndly_pkg::NUM_PAIRS-1:0]                 clk_out,
    output logic [dyndly_pkg::NUM_PAIRS-1:0]                 pair_busy
);
    import dyndly_pkg::*;

    // Synchroniser for the asynchronous sync pin.
    logic       sync_ff1_r;
    logic       sync_ff2_r;
    logic       sync_ff3_r;
    logic       sync_lvl_r;
    logic       sync_lvl_nxt;
    logic       sync_event;

    always_comb begin
        sync_lvl_nxt = sync_lvl_r;
        if (sync_ff2_r == sync_ff3_r) begin
            sync_lvl_nxt = sync_ff3_r;
        end
    end

    assign sync_event = sync_lvl_nxt && !sync_lvl_r;

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            sync_ff1_r <= 1'b0;
            sync_ff2_r <= 1'b0;
            sync_ff3_r <= 1'b0;
            sync_lvl_r <= 1'b0;
        end else begin
            sync_ff1_r <= sync_req;
            sync_ff2_r <= sync_ff1_r;
            sync_ff3_r <= sync_ff2_r;
            sync_lvl_r <= sync_lvl_nxt;
        end
    end

    // Per-pair state.
    dyndly_state_t               state_r   [NUM_PAIRS];
    dyndly_state_t               state_nxt [NUM_PAIRS];
    dyndly_cfg_t                 act_r     [NUM_PAIRS];
    dyndly_cfg_t                 act_nxt   [NUM_PAIRS];
    logic [WAIT_W-1:0]           wait_r    [NUM_PAIRS];
    logic [WAIT_W-1:0]           wait_nxt  [NUM_PAIRS];
    logic [NUM_PAIRS-1:0]        busy_nxt;
    logic [NUM_PAIRS-1:0]        busy_r;
    logic [NUM_PAIRS-1:0]        halt;
    logic [NUM_PAIRS-1:0]        restart;
    logic [NUM_PAIRS-1:0]        rise_now;
    logic                        qual_rise;
    logic [DIV_W-1:0]            qual_div;
    logic [SEL_W-1:0]            qual_sel_r;
    logic [SEL_W-1:0]            qual_sel_nxt;

    // The qualifier choice is also held until a sync so the reference does not
    // jump under a pair that is already counting.
    always_comb begin
        qual_sel_nxt = qual_sel_r;
        if (sync_event) begin
            qual_sel_nxt = qualifier_select; // R12
        end
    end

    // Out-of-range selections fall back to pair zero.
    always_comb begin
        // A qualifier that is itself held low has no edge to offer.
        qual_rise = rise_now[0] && (state_r[0] != ST_WAIT);
        qual_div  = act_r[0].divide;
        for (int i = 0; i < NUM_PAIRS; i++) begin
            if (qual_sel_r == SEL_W'(i)) begin
                qual_rise = rise_now[i] && (state_r[i] != ST_WAIT); // R4
                qual_div  = act_r[i].divide; // R10
            end
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_PAIRS; i++) begin
            state_nxt[i] = state_r[i];
            act_nxt[i]   = act_r[i];
            wait_nxt[i]  = wait_r[i];
            halt[i]      = 1'b0;
            restart[i]   = 1'b0;
            case (state_r[i])
                ST_RUN: begin
                    if (sync_event && sync_enable[i]) begin
                        act_nxt[i]   = pair_cfg[i]; // R12
                        state_nxt[i] = ST_ARM;
                    end
                end
                ST_ARM: begin
                    // Keep toggling until the reference edge, so the gap on the
                    // output is only the programmed wait.
                    if (qual_rise) begin
                        // Wait = delay + latency + one qualifier half period.
                        wait_nxt[i]  = eff_delay_half(act_r[i]) + SYNC_LAT_HALF
                                       + {{(WAIT_W-DIV_W){1'b0}}, qual_div}; // R1 R2 R7 R10
                        halt[i]      = 1'b1; // R8
                        state_nxt[i] = ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (wait_r[i] <= WAIT_ONE) begin
                        restart[i]   = 1'b1; // R5
                        state_nxt[i] = ST_RUN;
                    end else begin
                        halt[i]     = 1'b1; // R8
                        wait_nxt[i] = wait_r[i] - WAIT_ONE; // R2
                    end
                end
                default: begin
                    state_nxt[i] = ST_RUN;
                end
            endcase
            busy_nxt[i] = (state_nxt[i] != ST_RUN); // R9
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            qual_sel_r <= '0;
            busy_r     <= '0;
            for (int i = 0; i < NUM_PAIRS; i++) begin
                state_r[i] <= ST_RUN;
                act_r[i]   <= CFG_RESET;
                wait_r[i]  <= '0;
            end
        end else begin
            qual_sel_r <= qual_sel_nxt;
            busy_r     <= busy_nxt;
            for (int i = 0; i < NUM_PAIRS; i++) begin
                state_r[i] <= state_nxt[i];
                act_r[i]   <= act_nxt[i];
                wait_r[i]  <= wait_nxt[i];
            end
        end
    end

    assign pair_busy = busy_r;

    for (genvar g = 0; g < NUM_PAIRS; g++) begin : g_pair
        dyndly_div u_div (
            .ref_clk  (ref_clk),
            .reset_n  (reset_n),
            .divide   (act_r[g].divide),
            .halt     (halt[g]),
            .restart  (restart[g]),
            .clk_out  (clk_out[g]),
            .rise_now (rise_now[g])
        );
    end

endmodule // dyndly_top

// ==== common/dyndly_pkg.sv ====
// Shared constants, types and helpers of the dynamic output delay block.
package dyndly_pkg;

    localparam int NUM_PAIRS = 6;
    localparam int DDLY_W    = 10;
    localparam int DIV_W     = 11;
    localparam int SEL_W     = 3;
    localparam int WAIT_W    = 13;

    // One ref_clk cycle stands for half a period of the distribution clock.
    // Fixed path latency from the qualifying edge, in half periods (11.5 periods).
    localparam logic [WAIT_W-1:0] SYNC_LAT_HALF  = 13'h0017;
    // Smallest supported digital delay, 4.5 periods, in half periods.
    localparam logic [WAIT_W-1:0] DELAY_MIN_HALF = 13'h0009;
    localparam logic [WAIT_W-1:0] WAIT_ONE       = 13'h0001;
    localparam logic [DIV_W-1:0]  DIV_ONE        = 11'h001;
    localparam logic [DIV_W-1:0]  DIV_RESET      = 11'h008;
    localparam logic [DDLY_W-1:0] DDLY_RESET     = 10'h005;

    typedef struct packed {
        logic [DIV_W-1:0]  divide;
        logic [DDLY_W-1:0] delay_count;
        logic              half_step;
    } dyndly_cfg_t;

    localparam dyndly_cfg_t CFG_RESET = '{divide: DIV_RESET, delay_count: DDLY_RESET,
                                          half_step: 1'b0};

    typedef enum logic [1:0] {
        ST_RUN  = 2'b00,
        ST_ARM  = 2'b01,
        ST_WAIT = 2'b10
    } dyndly_state_t;

    // Delay in half periods: twice the count, less one when the half step is set.
    function automatic logic [WAIT_W-1:0] eff_delay_half(input dyndly_cfg_t c);
        logic [WAIT_W-1:0] d;
        d = {2'b00, c.delay_count, 1'b0} - {{(WAIT_W-1){1'b0}}, c.half_step};
        // A zero count with the half step set would wrap, so it is caught too.
        if (d < DELAY_MIN_HALF || c.delay_count == '0) begin
            d = DELAY_MIN_HALF;
        end
        return d;
    endfunction

endpackage

// ==== src/dyndly_div.sv ====
// Half-period stepped 50 % duty divider for one output pair.
`timescale 1ns/1ps
module dyndly_div (
    input  wire logic                         ref_clk,
    input  wire logic                         reset_n,
    input  wire logic [dyndly_pkg::DIV_W-1:0] divide,
    input  wire logic                         halt,
    input  wire logic                         restart,
    output logic                              clk_out,
    output logic                              rise_now
);
    import dyndly_pkg::*;

    logic [DIV_W-1:0] cnt_r;
    logic [DIV_W-1:0] cnt_nxt;
    logic             out_r;
    logic             out_nxt;
    logic             end_of_phase;

    // Each phase lasts divide half periods, so odd divides keep 50 % duty.
    assign end_of_phase = (cnt_r >= divide - DIV_ONE);
    // The rise forecast ignores halt and restart. The top builds halt from this
    // forecast, so gating it here would close a combinational loop.
    assign rise_now     = !out_r && end_of_phase;
    assign clk_out      = out_r;

    always_comb begin
        cnt_nxt = cnt_r + DIV_ONE;
        out_nxt = out_r;
        if (restart) begin
            cnt_nxt = '0;
            out_nxt = 1'b1;
        end else if (halt) begin
            cnt_nxt = '0;
            out_nxt = 1'b0;
        end else if (end_of_phase) begin
            cnt_nxt = '0;
            out_nxt = !out_r;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            cnt_r <= '0;
            out_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            out_r <= out_nxt;
        end
    end

endmodule // dyndly_div

// ==== bench/dyndly_host.sv ====
// Host model that programs the pair settings and raises the sync pin.
`timescale 1ns/1ps
module dyndly_host (
    input  wire logic                                   ref_clk,
    output logic                                        sync_req,
    output logic [dyndly_pkg::SEL_W-1:0]                qualifier_select,
    output logic [dyndly_pkg::NUM_PAIRS-1:0]            sync_enable,
    output dyndly_pkg::dyndly_cfg_t [dyndly_pkg::NUM_PAIRS-1:0] pair_cfg
);
    import dyndly_pkg::*;
    localparam logic [DIV_W-1:0] DIV_Q = 11'h00A;

    initial begin
        sync_req = 1'b0;
        qualifier_select = '0;
        sync_enable = '0;
        pair_cfg = {NUM_PAIRS{CFG_RESET}};
    end

    // Zero offset setting in half steps; never below the smallest usable delay.
    function automatic int zero_half(input int div);
        return (2 * ((16 + div - 1) / div) + 1) * div - 23;
    endfunction

    // The half step is written with the count, as the sync needs it.
    task automatic sync_with(input int q, input int en, input int dc, input int hs);
        @(posedge ref_clk);
        qualifier_select <= SEL_W'(q);
        sync_enable <= NUM_PAIRS'(en);
        for (int i = 0; i < NUM_PAIRS; i++) pair_cfg[i] <= '{DIV_Q, DDLY_W'(dc), hs[0]};
        sync_req <= 1'b1;
        repeat (5) @(posedge ref_clk);
        sync_req <= 1'b0;
        // Second pass: the half step returns to rest; the latched setting must not follow.
        for (int i = 0; i < NUM_PAIRS; i++) pair_cfg[i].half_step <= 1'b0;
    endtask
endmodule // dyndly_host

// ==== bench/dyndly_asserts.sv ====
// Port checks of the dynamic output delay block.
`timescale 1ns/1ps
module dyndly_asserts (
    input wire logic                             ref_clk,
    input wire logic                             reset_n,
    input wire logic                             sync_req,
    input wire logic [dyndly_pkg::NUM_PAIRS-1:0] sync_enable,
    input wire logic [dyndly_pkg::NUM_PAIRS-1:0] clk_out,
    input wire logic [dyndly_pkg::NUM_PAIRS-1:0] pair_busy
);
    import dyndly_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    logic [11:0] lo_r;
    logic [11:0] lo_nxt;

    // Saturates so that a very long forced low cannot wrap back to a short count.
    always_comb begin
        lo_nxt = clk_out[0] ? 12'h000 : lo_r + {11'h000, ~&lo_r};
    end
    always_ff @(posedge ref_clk) begin
        lo_r <= reset_n ? lo_nxt : 12'h000;
    end

    restart_high_a: assert property ($fell(pair_busy[0]) |-> $rose(clk_out[0]))
        else $error("restart did not raise the output");
    off_time_a: assert property ($fell(pair_busy[0]) |-> lo_r >= 12'h01F)
        else $error("forced low shorter than the minimum delay");
    idle_toggle_a: assert property (!pair_busy[0] && !$past(pair_busy[0]) |-> lo_r <= 12'h800)
        else $error("idle output stopped toggling");
    sync_cause_a: assert property ($rose(pair_busy[0]) |-> $past(sync_req, 3))
        else $error("busy without a sync event");
    enabled_only_a: assert property ((pair_busy & ~$past(pair_busy) & ~$past(sync_enable, 3)) == '0)
        else $error("pair not enabled went busy");
    busy_min_a: assert property ($rose(pair_busy[1]) |-> pair_busy[1] [*8])
        else $error("busy too short");
    settle_a: assert property ($fell(pair_busy[1]) |=> !pair_busy[1])
        else $error("busy again right after restart");
    all_restart_a: assert property ((~pair_busy & $past(pair_busy) & ~clk_out) == '0)
        else $error("a pair restarted low");
endmodule // dyndly_asserts

bind dyndly_top dyndly_asserts i_dyndly_asserts (.ref_clk(ref_clk), .reset_n(reset_n),
    .sync_req(sync_req), .sync_enable(sync_enable), .clk_out(clk_out), .pair_busy(pair_busy));

// ==== bench/dyndly_tb.sv ====
// Self-checking bench of the dynamic output delay block.
`timescale 1ns/1ps
module dyndly_tb;
    import dyndly_pkg::*;
    logic                           ref_clk = 1'b0;
    logic                           reset_n = 1'b0;
    logic                           sync_req;
    logic [SEL_W-1:0]               qualifier_select;
    logic [NUM_PAIRS-1:0]           sync_enable;
    dyndly_cfg_t [NUM_PAIRS-1:0]    pair_cfg;
    logic [NUM_PAIRS-1:0]           clk_out;
    logic [NUM_PAIRS-1:0]           pair_busy;
    logic [NUM_PAIRS-1:0]           prv = '0;
    logic [NUM_PAIRS-1:0]           rise = '0;
    int n_fail = 0;
    int n_checks = 0;
    int cyc = 0;
    int dur [9];
    // Columns: qualifier, enables, count, half step, measured pair, reference pair, syncs.
    int rows [9][7] = '{'{0, 63, 14, 1, 5, 0, 1}, '{0, 2, 14, 1, 1, 0, 1},
        '{0, 2, 14, 0, 1, 0, 1}, '{0, 2, 13, 1, 1, 0, 1}, '{0, 2, 5, 1, 1, 0, 1},
        '{0, 2, 15, 1, 1, 0, 1}, '{0, 1, 14, 0, 0, 3, 1}, '{0, 1, 14, 0, 0, 3, 2},
        '{3, 2, 14, 1, 1, 3, 1}};

    dyndly_top i_dyndly_top (.ref_clk(ref_clk), .reset_n(reset_n), .sync_req(sync_req),
        .qualifier_select(qualifier_select), .sync_enable(sync_enable),
        .pair_cfg(pair_cfg), .clk_out(clk_out), .pair_busy(pair_busy));
    dyndly_host i_dyndly_host (.ref_clk(ref_clk), .sync_req(sync_req),
        .qualifier_select(qualifier_select), .sync_enable(sync_enable), .pair_cfg(pair_cfg));

    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        #1;
        rise = clk_out & ~prv;
        prv = clk_out;
        cyc++;
        if (cyc == 6000) begin
            n_fail++;
            summarize();
        end
    end

    task automatic check(input int got, input int exp);
        n_checks++;
        if (got != exp) begin
            n_fail++;
            $display("BAD t=%0t got %0d expected %0d", $time, got, exp);
        end
    endtask

    // Syncs just after a qualifier rise, then times the busy span and the phase offset.
    task automatic run(input int r[7], output int dt);
        int n;
        n = 0;
        while (rise[r[0]] !== 1'b1 && n < 60) begin
            @(negedge ref_clk);
            n++;
        end
        check(int'(n < 60), 1);
        i_dyndly_host.sync_with(r[0], r[1], r[2], r[3]);
        @(negedge ref_clk);
        check(int'(pair_busy[r[4]] === 1'b1), 1);
        dt = 0;
        while (pair_busy[r[4]] === 1'b1 && dt < 400) begin
            @(negedge ref_clk);
            dt++;
        end
        check(int'(dt < 400), 1);
        n = 0;
        while (rise[r[5]] !== 1'b1 && n < 40) begin
            @(negedge ref_clk);
            n++;
        end
        check(int'(n < 40), 1);
        check((20 - n) % 20, (r[6] * (2 * r[2] - r[3] - i_dyndly_host.zero_half(10)) + 40) % 20);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'b1;
        foreach (rows[i]) begin
            run(rows[i], dur[i]);
            $display("test %0d done", i);
        end
        check(dur[5] - dur[4], 20);
        summarize();
    end
endmodule // dyndly_tb
